/* File: t1_alarm_pkg.sv */
// Constants shared by the receive alarm and status block.
// Assumes a receive line clock at the nominal T1 line rate.
package t1_alarm_pkg;

  // Register map
  localparam logic [7:0] SR1_ADDR  = 8'h20;  // Receive alarm status
  localparam logic [7:0] IRQ_MASK_ONE_ADDR = 8'h7F;  // Interrupt mask one

  // Bit positions of the receive alarm status register
  localparam int BIT_LOOPUP    = 7;
  localparam int BIT_LOOPDOWN  = 6;
  localparam int BIT_TXCLK     = 5;
  localparam int BIT_SLIP      = 4;
  localparam int BIT_BLUE      = 3;
  localparam int BIT_YELLOW    = 2;
  localparam int BIT_RED       = 1;
  localparam int BIT_SYNC      = 0;
  localparam int BIT_ISR_SR1   = 0;   // This framer's summary bit

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'h00;

  // Line rate and times
  localparam int LINE_RATE_KHZ      = 1544;
  localparam int TX_LOSS_TIME_NS    = 5200;
  localparam int TX_LOSS_CYCLES     = TX_LOSS_TIME_NS * LINE_RATE_KHZ
                                      / 1000000;
  localparam int BLUE_WINDOW_MS     = 3;
  localparam int BLUE_WINDOW_CYCLES = BLUE_WINDOW_MS * LINE_RATE_KHZ;
  localparam int LOOP_INTEGRATE_MS  = 48;
  localparam int LOOP_WINDOW_CYCLES = LOOP_INTEGRATE_MS * LINE_RATE_KHZ;

  // Alarm thresholds
  localparam int BLUE_SET_MAX_ZEROS = 5;
  localparam int BLUE_CLR_MIN_ZEROS = 6;
  localparam int RED_ZERO_RUN       = 192;
  localparam int RED_SPAN_BITS      = 112;
  localparam int RED_ONES_NEEDED    = 14;
  localparam int YEL_BLOCK_CHANNELS = 256;
  localparam int YEL_MIN_ZEROS      = 254;
  localparam int FDL_BLOCK          = 16;
  localparam int FDL_CLEAR_MAX      = 14;

  // Loop codes: 00001 and 001, one mark per period
  localparam int LOOPUP_PERIOD   = 5;
  localparam int LOOPDOWN_PERIOD = 3;

  // Counter widths
  localparam int LOOP_HIST_W = 8;
  localparam int LOOP_CNT_W  = 17;
  localparam int LOOP_PROD_W = 20;
  localparam int BLUE_CNT_W  = 16;

endpackage

/* File: loop_code_if.sv */
// Carries the line bit stream to a loop code detector and its result.
// Assumes both ends run on the receive line clock.
`timescale 1ns/1ns
interface loop_code_if;
  logic line_bit;  // Recovered line bit, one per clock
  logic detected;  // Code present over the last window

  modport detector (input line_bit, output detected);
  modport source   (output line_bit, input detected);
endinterface

/* File: loop_code_detector.sv */
// Loop code detector for a repeating code with one mark per period.
// Assumes one line bit per clock of the receive line clock.
`timescale 1ns/1ns
module loop_code_detector
  import t1_alarm_pkg::*;
#(
  parameter int unsigned PERIOD = LOOPUP_PERIOD,
  parameter int unsigned WINDOW = LOOP_WINDOW_CYCLES
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           resetn,
  // Stream and result
  loop_code_if.detector       lc
);

  // Tolerances widened to product width
  localparam logic [LOOP_PROD_W-1:0] WIN_W  = LOOP_PROD_W'(WINDOW);
  localparam logic [LOOP_PROD_W-1:0] DEN_LO = WIN_W - (WIN_W >> 3);
  localparam logic [LOOP_PROD_W-1:0] DEN_HI = WIN_W + (WIN_W >> 3);
  localparam logic [LOOP_PROD_W-1:0] MIS_TL = WIN_W >> 4;
  localparam logic [LOOP_CNT_W-1:0]  LAST   = LOOP_CNT_W'(WINDOW - 1);

  typedef struct packed {
    logic [LOOP_HIST_W-1:0] hist;  // Previous line bits
    logic [LOOP_CNT_W-1:0]  bits;  // Position in window
    logic [LOOP_CNT_W-1:0]  mism;  // Bits unlike one period ago
    logic [LOOP_CNT_W-1:0]  ones;  // Marks seen in window
    logic                   det;   // Held result
  } loop_state_type;

  loop_state_type q;    // Registered state
  loop_state_type d;    // Next state

  logic [LOOP_PROD_W-1:0] scaled;  // Marks times period

  assign lc.detected = q.det;

  // Periodicity and density integration over one window
  always_comb begin
    d      = q;
    scaled = LOOP_PROD_W'(q.ones) * LOOP_PROD_W'(PERIOD);
    d.hist = {q.hist[LOOP_HIST_W-2:0], lc.line_bit};
    // Compare with the bit one period back
    if (lc.line_bit != q.hist[PERIOD-1]) begin
      d.mism = q.mism + 1'b1;
    end
    if (lc.line_bit) begin
      d.ones = q.ones + 1'b1;
    end
    if (q.bits == LAST) begin
      // Window end: judge and restart
      d.det  = (LOOP_PROD_W'(q.mism) <= MIS_TL) &&
               (scaled >= DEN_LO) && (scaled <= DEN_HI);
      d.bits = '0;
      d.mism = '0;
      d.ones = '0;
    end else begin
      d.bits = q.bits + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

/* File: t1_receive_alarm_status.sv */
// Receive alarm detection and status register for one T1 framer.
// Assumes line rails and framer strobes arrive on rx_line_clock, and
// the register port and control inputs run on clk.
//
// Overview of operation
// - Status bit 7 flags repeating loop-up code
// - Status bit 6 flags repeating loop-down code
// - Bit 5 flags transmit clock stalled 5.2 us
// - Clock loss drives shared loss pin if enabled
// - Clock loss moves transmit timing to receive clock
// - Bit 4 flags receive elastic store slip
// - Blue alarm: few zeros per 3 ms window
// - D4 bit-2 yellow: 254 of 256 zero
// - D4 12th F-bit yellow: two equal occurrences
// - ESF yellow: sixteen 00FF patterns in link
// - Red alarm after 192 consecutive zeros
// - Red clears: 14 ones within 112 bits
// - Bit 0 holds while framer out of sync
// - Loop detector integrates 48 ms, tolerates errors
// - Status cleared by write-read-write sequence
// - Unmasked status events drive active-low interrupt
// - Summary register shows active status interrupt
`timescale 1ns/1ns
module t1_receive_alarm_status
  import t1_alarm_pkg::*;
#(
  parameter int BLUE_WINDOW = BLUE_WINDOW_CYCLES,
  parameter int LOOP_WINDOW = LOOP_WINDOW_CYCLES
) (
  // System clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Line side, receive line clock domain
  input  wire logic       rx_line_clock,
  input  wire logic       rx_positive_rail,
  input  wire logic       rx_negative_rail,
  input  wire logic       tx_line_clock,
  // Framer strobes, receive line clock domain
  input  wire logic       rx_in_sync,
  input  wire logic       rx_slip_pulse,
  input  wire logic       chan_bit2_valid,
  input  wire logic       chan_bit2,
  input  wire logic       fbit12_valid,
  input  wire logic       fbit12,
  input  wire logic       fdl_pattern_valid,
  input  wire logic       fdl_is_00ff,
  // Control bits, system clock domain
  input  wire logic       yellow_fbit12_mode,
  input  wire logic       esf_mode,
  input  wire logic       clock_loss_pin_enable,
  input  wire logic       tx_fallback_enable,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Alarm outputs
  output logic            sync_or_clock_loss_pin,
  output logic            tx_clock_select_rx,
  output logic            irq_n
);

  ////////////////////////////////////////////////////////////////////
  // Link domain state
  ////////////////////////////////////////////////////////////////////

  localparam logic [3:0] TXL_LIMIT   = 4'(TX_LOSS_CYCLES);
  localparam logic [7:0] RED_RUN     = 8'(RED_ZERO_RUN - 1);
  localparam logic [6:0] RED_SPAN    = 7'(RED_SPAN_BITS - 1);
  localparam logic [3:0] RED_ONES    = 4'(RED_ONES_NEEDED);
  localparam logic [BLUE_CNT_W-1:0] BLUE_LAST =
    BLUE_CNT_W'(BLUE_WINDOW - 1);
  localparam logic [2:0] BLUE_SET    = 3'(BLUE_SET_MAX_ZEROS);
  localparam logic [2:0] BLUE_CLR    = 3'(BLUE_CLR_MIN_ZEROS);
  localparam logic [7:0] YEL_LAST    = 8'(YEL_BLOCK_CHANNELS - 1);
  localparam logic [8:0] YEL_MIN     = 9'(YEL_MIN_ZEROS);
  localparam logic [4:0] FDL_RUN     = 5'(FDL_BLOCK);
  localparam logic [3:0] FDL_LAST    = 4'(FDL_BLOCK - 1);
  localparam logic [4:0] FDL_CLR     = 5'(FDL_CLEAR_MAX);

  typedef struct packed {
    logic [2:0]            txs;       // Tx clock sync and last level
    logic [3:0]            tx_cnt;    // Cycles since tx clock edge
    logic                  tx_lost;   // Transmit clock loss
    logic [1:0]            mode_s1;   // Mode sync, first stage
    logic [1:0]            mode_s2;   // Mode sync, second stage
    logic [7:0]            zero_run;  // Consecutive zeros
    logic                  red;       // Carrier loss alarm
    logic                  red_arm;   // Clear span in progress
    logic [6:0]            red_span;  // Position in clear span
    logic [3:0]            red_ones;  // Ones in clear span
    logic [BLUE_CNT_W-1:0] blue_cnt;  // Position in blue window
    logic [2:0]            blue_zero; // Zeros, saturating
    logic                  blue;      // Blue alarm
    logic [7:0]            yel_chan;  // Channel in bit-2 block
    logic [8:0]            yel_zero;  // Zero bit-2 count
    logic                  fb_prev;   // Previous 12th F-bit
    logic [4:0]            fdl_run;   // Consecutive 00FF
    logic [3:0]            fdl_blk;   // Pattern in block
    logic [4:0]            fdl_hit;   // 00FF in block
    logic                  yellow;    // Yellow alarm
    logic                  slip_tgl;  // Toggles per slip
  } link_state_type;

  link_state_type lq;   // Registered link state
  link_state_type ld;   // Next link state

  loop_code_if up_if ();    // Loop-up detector link
  loop_code_if down_if ();  // Loop-down detector link

  logic line_one;           // Bipolar mark received

  assign line_one         = rx_positive_rail | rx_negative_rail;
  assign up_if.line_bit   = line_one;
  assign down_if.line_bit = line_one;

  // Loop-up code detector
  loop_code_detector #(
    .PERIOD (LOOPUP_PERIOD),
    .WINDOW (LOOP_WINDOW)
  ) u_loopup (
    .clk    (rx_line_clock),
    .resetn (resetn),
    .lc     (up_if.detector)
  );

  // Loop-down code detector
  loop_code_detector #(
    .PERIOD (LOOPDOWN_PERIOD),
    .WINDOW (LOOP_WINDOW)
  ) u_loopdown (
    .clk    (rx_line_clock),
    .resetn (resetn),
    .lc     (down_if.detector)
  );

  // Line alarm detectors
  always_comb begin
    ld = lq;
    // Transmit clock watchdog on receive clock
    ld.txs = {lq.txs[1:0], tx_line_clock};
    if (lq.txs[2] != lq.txs[1]) begin
      ld.tx_cnt  = '0;
      ld.tx_lost = 1'b0;
    end else if (lq.tx_cnt < TXL_LIMIT) begin
      ld.tx_cnt = lq.tx_cnt + 1'b1;
    end else begin
      ld.tx_lost = 1'b1;
    end
    // Mode bits from system domain
    ld.mode_s1 = {esf_mode, yellow_fbit12_mode};
    ld.mode_s2 = lq.mode_s1;
    // Carrier loss set on long zero run
    if (line_one) begin
      ld.zero_run = '0;
    end else if (lq.zero_run != RED_RUN) begin
      ld.zero_run = lq.zero_run + 1'b1;
    end else begin
      ld.red = 1'b1;
    end
    // Carrier loss clear span opened by first one
    if (lq.red && !(lq.zero_run == RED_RUN && !line_one)) begin
      if (!lq.red_arm) begin
        if (line_one) begin
          ld.red_arm  = 1'b1;
          ld.red_span = '0;
          ld.red_ones = 4'h1;
        end
      end else begin
        if (line_one) begin
          ld.red_ones = lq.red_ones + 1'b1;
        end
        if (line_one && lq.red_ones == RED_ONES - 1'b1) begin
          ld.red     = 1'b0;
          ld.red_arm = 1'b0;
        end else if (lq.red_span == RED_SPAN - 1'b1) begin
          ld.red_arm = 1'b0;  // Span spent, wait for next one
        end else begin
          ld.red_span = lq.red_span + 1'b1;
        end
      end
    end else begin
      ld.red_arm = 1'b0;
    end
    // Blue alarm window counted on line clock
    if (!line_one && lq.blue_zero != BLUE_CLR) begin
      ld.blue_zero = lq.blue_zero + 1'b1;
    end
    if (lq.blue_cnt == BLUE_LAST) begin
      if (lq.blue_zero <= BLUE_SET) begin
        ld.blue = 1'b1;
      end else begin
        ld.blue = 1'b0;
      end
      ld.blue_cnt  = '0;
      ld.blue_zero = '0;
    end else begin
      ld.blue_cnt = lq.blue_cnt + 1'b1;
    end
    // Yellow alarm by selected mode
    if (lq.mode_s2[1]) begin
      // Data link 00FF patterns
      if (fdl_pattern_valid) begin
        ld.fdl_run = fdl_is_00ff ? ((lq.fdl_run == FDL_RUN) ?
                     lq.fdl_run : lq.fdl_run + 1'b1) : '0;
        if (fdl_is_00ff && lq.fdl_run == FDL_RUN - 1'b1) begin
          ld.yellow = 1'b1;
        end
        if (lq.fdl_blk == FDL_LAST) begin
          if (lq.fdl_hit + 5'(fdl_is_00ff) <= FDL_CLR) begin
            ld.yellow = 1'b0;
          end
          ld.fdl_blk = '0;
          ld.fdl_hit = '0;
        end else begin
          ld.fdl_blk = lq.fdl_blk + 1'b1;
          ld.fdl_hit = lq.fdl_hit + 5'(fdl_is_00ff);
        end
      end
    end else if (lq.mode_s2[0]) begin
      // Twelfth framing bit, two alike in a row
      if (fbit12_valid) begin
        ld.fb_prev = fbit12;
        if (fbit12 && lq.fb_prev) begin
          ld.yellow = 1'b1;
        end else if (!fbit12 && !lq.fb_prev) begin
          ld.yellow = 1'b0;
        end
      end
    end else begin
      // Bit 2 of each channel over blocks of 256
      if (chan_bit2_valid) begin
        if (lq.yel_chan == YEL_LAST) begin
          ld.yellow   = (lq.yel_zero + 9'(!chan_bit2)) >= YEL_MIN;
          ld.yel_chan = '0;
          ld.yel_zero = '0;
        end else begin
          ld.yel_chan = lq.yel_chan + 1'b1;
          ld.yel_zero = lq.yel_zero + 9'(!chan_bit2);
        end
      end
    end
    // Slip pulse becomes a toggle for the crossing
    if (rx_slip_pulse) begin
      ld.slip_tgl = ~lq.slip_tgl;
    end
  end

  // Link state register
  always_ff @(posedge rx_line_clock or negedge resetn) begin
    if (!resetn) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // System domain state
  ////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [7:0] cs1;       // Condition sync, first stage
    logic [7:0] cs2;       // Condition sync, second stage
    logic       slip_prev; // Last synced slip toggle
    logic [7:0] held;      // Latched status
    logic [7:0] readc;     // Readable copy
    logic [7:0] imr;       // Interrupt mask
    logic [7:0] rdata;     // Read data
    logic       pin;       // Shared loss pin
    logic       fallback;  // Transmit timing from receive clock
    logic       irq_n;     // Interrupt, active low
  } sys_state_type;

  sys_state_type sq;    // Registered system state
  sys_state_type sd;    // Next system state

  logic [7:0] cond;     // Link conditions into crossing
  logic [7:0] live;     // Synced conditions and slip event
  logic       sr1_irq;  // Unmasked status active

  // Condition vector, one bit per status position
  always_comb begin
    cond               = '0;
    cond[BIT_LOOPUP]   = up_if.detected;
    cond[BIT_LOOPDOWN] = down_if.detected;
    cond[BIT_TXCLK]    = lq.tx_lost;
    cond[BIT_SLIP]     = lq.slip_tgl;
    cond[BIT_BLUE]     = lq.blue;
    cond[BIT_YELLOW]   = lq.yellow;
    cond[BIT_RED]      = lq.red;
    cond[BIT_SYNC]     = !rx_in_sync;
  end

  // Levels pass through; slip toggle becomes a one-cycle event
  always_comb begin
    live           = sq.cs2;
    live[BIT_SLIP] = sq.cs2[BIT_SLIP] ^ sq.slip_prev;
  end

  assign sr1_irq = |(sq.held & sq.imr);

  // Status latching, register port and alarm pins
  always_comb begin
    sd           = sq;
    sd.cs1       = cond;
    sd.cs2       = sq.cs1;
    sd.slip_prev = sq.cs2[BIT_SLIP];
    // Write of ones copies and clears; live condition sets again
    if (reg_write && reg_addr == SR1_ADDR) begin
      sd.readc = (sq.readc & ~reg_wdata) |
                 (sq.held & reg_wdata);
      sd.held  = (sq.held & ~reg_wdata) | live;
    end else begin
      sd.held  = sq.held | live;
    end
    if (reg_write && reg_addr == IRQ_MASK_ONE_ADDR) begin
      sd.imr = reg_wdata;
    end
    // Reads; any other address shows the summary
    if (reg_read) begin
      if (reg_addr == SR1_ADDR) begin
        sd.rdata = sq.readc;
      end else if (reg_addr == IRQ_MASK_ONE_ADDR) begin
        sd.rdata = sq.imr;
      end else begin
        sd.rdata              = '0;
        sd.rdata[BIT_ISR_SR1] = sr1_irq;
      end
    end
    sd.pin      = sq.cs2[BIT_SYNC] |
                  (clock_loss_pin_enable & sq.cs2[BIT_TXCLK]);
    sd.fallback = tx_fallback_enable & sq.cs2[BIT_TXCLK];
    sd.irq_n    = !sr1_irq;
  end

  // System state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sq          <= '0;
      sq.held     <= STATUS_RESET;
      sq.readc    <= STATUS_RESET;
      sq.imr      <= MASK_RESET;
      sq.irq_n    <= 1'b1;
    end else begin
      sq <= sd;
    end
  end

  // Outputs from flops
  assign reg_rdata              = sq.rdata;
  assign sync_or_clock_loss_pin = sq.pin;
  assign tx_clock_select_rx     = sq.fallback;
  assign irq_n                  = sq.irq_n;

endmodule

/* File: t1_alarm_properties.sv */
// Checker for the receive alarm status block, ports only.
// Assumes it is bound to the top module and clk is the register clock.
`timescale 1ns/1ns
module t1_alarm_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       resetn,
  // Inputs watched
  input wire logic       rx_in_sync,
  input wire logic       clock_loss_pin_enable,
  input wire logic       tx_fallback_enable,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_wdata,
  // Outputs judged
  input wire logic [7:0] reg_rdata,
  input wire logic       sync_or_clock_loss_pin,
  input wire logic       tx_clock_select_rx,
  input wire logic       irq_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  // Bit 0 write after a long sync loss
  sequence s_sync_wr;
    (!rx_in_sync)[*8] ##0 (reg_write && reg_addr == 8'h20 && reg_wdata[0]);
  endsequence
  // Status read with sync still lost
  sequence s_sync_rd;
    reg_read && reg_addr == 8'h20 && !rx_in_sync;
  endsequence
  // Read of the summary place
  sequence s_sum_rd;
    reg_read && reg_addr != 8'h20 && reg_addr != 8'h7F;
  endsequence
  property p_rdata_hold;
    !reg_read |=> $stable(reg_rdata);
  endproperty
  property p_sync_read;
    s_sync_wr ##2 s_sync_rd |=> reg_rdata[0];
  endproperty
  property p_summary_upper;
    s_sum_rd |=> reg_rdata[7:1] == 7'h00;
  endproperty
  property p_summary_irq;
    (!irq_n && !reg_write)[*2] ##0 s_sum_rd |=> reg_rdata[0];
  endproperty
  property p_pin_set;
    (!rx_in_sync)[*8] |-> sync_or_clock_loss_pin;
  endproperty
  property p_pin_clear;
    (rx_in_sync && !clock_loss_pin_enable)[*8] |-> !sync_or_clock_loss_pin;
  endproperty
  property p_fallback_off;
    (!tx_fallback_enable)[*4] |-> !tx_clock_select_rx;
  endproperty
  property p_irq_masked;
    (reg_write && reg_addr == 8'h7F && reg_wdata == 8'h00)
      ##1 (!(reg_write && reg_addr == 8'h7F))[*3] |-> irq_n;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  a_sync_read: assert property (p_sync_read)
    else $error("sync loss not in copy");
  a_summary_upper: assert property (p_summary_upper)
    else $error("summary upper bits not zero");
  a_summary_irq: assert property (p_summary_irq)
    else $error("summary bit low");
  a_pin_set: assert property (p_pin_set)
    else $error("loss pin low while out of sync");
  a_pin_clear: assert property (p_pin_clear)
    else $error("loss pin high in sync");
  a_fallback_off: assert property (p_fallback_off)
    else $error("clock fallback without enable");
  a_irq_masked: assert property (p_irq_masked)
    else $error("irq with all masked");
endmodule

bind t1_receive_alarm_status t1_alarm_checker t1_alarm_checker_i (.*);

/* File: t1_line_partner.sv */
// Model of the line interface delivering bipolar receive data.
// Assumes the bench picks the mark spacing and the transmit clock run.
`timescale 1ns/1ns
module t1_line_partner (
  // Pattern control
  input  wire logic [3:0] period,
  input  wire logic       tx_run,
  // Line side
  output logic            rx_line_clock,
  output logic            rx_positive_rail,
  output logic            rx_negative_rail,
  output logic            tx_line_clock
);
  logic [3:0] cnt_q;  // Bit position within the period
  logic       pol_q;  // Rail of the next mark
  ////////////////////////////////////////////////////////////////////////
  // Free-running line clock, phase unrelated to clk
  initial begin
    rx_line_clock = 1'b0;
    tx_line_clock = 1'b0;
    cnt_q = 4'h0;
    pol_q = 1'b0;
    #7;
    forever #32 rx_line_clock = ~rx_line_clock;
  end
  // One mark per period bits, rails alternate; 0 = spaces
  always @(posedge rx_line_clock) begin
    if (period != 4'h0 && cnt_q >= period - 4'h1) begin
      rx_positive_rail <= !pol_q;
      rx_negative_rail <= pol_q;
      pol_q <= !pol_q;
      cnt_q <= 4'h0;
    end else begin
      rx_positive_rail <= 1'b0;
      rx_negative_rail <= 1'b0;
      cnt_q <= cnt_q + 4'h1;
    end
  end
  // Transmit clock toggles each bit while running
  always @(negedge rx_line_clock) begin
    if (tx_run) begin
      tx_line_clock <= ~tx_line_clock;
    end
  end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the receive alarm status block.
// Assumes shortened alarm windows and the line partner model.
`timescale 1ns/1ns
module tb_top;
  import t1_alarm_pkg::*;
  logic       clk, resetn, rx_line_clock, rx_positive_rail, rx_negative_rail;
  logic       tx_line_clock, tx_run, rx_in_sync, rx_slip_pulse;
  logic       chan_bit2_valid, chan_bit2, fbit12_valid, fbit12;
  logic       fdl_pattern_valid, fdl_is_00ff, yellow_fbit12_mode, esf_mode;
  logic       clock_loss_pin_enable, tx_fallback_enable, reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       sync_or_clock_loss_pin, tx_clock_select_rx, irq_n;
  logic [3:0] period;       // Mark spacing of the line pattern
  int         err_total;    // Mismatches seen
  int         comparisons;  // Comparisons made
  // Line cases: spacing, bits, status mask (0 = no look), expected
  int         lp[10] = '{0, 1, 0, 9, 8, 1, 2, 5, 3, 1};
  int         ln[10] = '{190, 20, 200, 300, 300, 200, 200, 500, 500, 500};
  logic [7:0] lm[10] = '{8'h00, 8'h02, 8'h02, 8'h02, 8'h02, 8'h08, 8'h08,
                         8'hC0, 8'hC0, 8'hC0};
  logic [7:0] le[10] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h00, 8'h08, 8'h00,
                         8'h80, 8'h40, 8'h00};
  // Yellow cases: mode, strobes, leading condition count, expected
  int         yk[8] = '{0, 0, 0, 1, 1, 1, 2, 2};
  int         yt[8] = '{256, 256, 256, 2, 2, 2, 16, 16};
  int         yn[8] = '{253, 254, 0, 1, 2, 0, 15, 16};
  logic [7:0] ye[8] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00,
                        8'h04};
  ////////////////////////////////////////////////////////////////////////
  t1_line_partner t1_line_partner_i (.*);
  t1_receive_alarm_status #(.BLUE_WINDOW(64), .LOOP_WINDOW(200))
    t1_receive_alarm_status_i (.*);
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task check(input string name, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task print_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Register write, one cycle
  task reg_wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // Register read, data settled the cycle after
  task reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    #1 v = reg_rdata;
  endtask
  // Write-read-write clear of chosen bits
  task sr(input logic [7:0] m, output logic [7:0] v);
    reg_wr(8'h20, m);
    reg_rd(8'h20, v);
    reg_wr(8'h20, v & m);
  endtask
  // Clear stale bits, report what sets again
  task probe(input logic [7:0] m, output logic [7:0] v);
    sr(m, v);
    repeat (10) @(posedge clk);
    sr(m, v);
    v = v & m;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reset values, copy, sync loss, mask, summary
  task t_regs();
    logic [7:0] v;
    reg_rd(8'h20, v); check("status reset", v, STATUS_RESET);
    reg_rd(8'h7F, v); check("mask reset", v, MASK_RESET);
    repeat (10) @(posedge clk);
    reg_wr(8'h20, 8'h00);
    reg_rd(8'h20, v); check("copy kept", v, 8'h00);
    check("loss pin", {7'h00, sync_or_clock_loss_pin}, 8'h01);
    sr(8'h01, v); check("sync lost", v, 8'h01);
    reg_wr(8'h20, 8'h00);
    reg_rd(8'h20, v); check("copy held", v, 8'h01);
    reg_wr(8'h7F, 8'h01);
    reg_wr(8'h05, 8'hFF);
    reg_rd(8'h7F, v); check("mask", v, 8'h01);
    check("irq on", {7'h00, irq_n}, 8'h00);
    reg_rd(8'h00, v); check("summary", v, 8'h01);
    reg_wr(8'h7F, 8'h00);
    repeat (4) @(posedge clk);
    check("irq off", {7'h00, irq_n}, 8'h01);
    rx_in_sync <= 1'b1;
    repeat (10) @(posedge clk);
    probe(8'h01, v); check("sync back", v, 8'h00);
  endtask
  // Transmit clock stall, pin and fallback
  task t_tx();
    logic [7:0] v;
    @(posedge clk);
    clock_loss_pin_enable <= 1'b1;
    tx_fallback_enable <= 1'b1;
    tx_run <= 1'b0;
    repeat (40) @(posedge rx_line_clock);
    probe(8'h20, v); check("tx lost", v, 8'h20);
    check("pin", {7'h00, sync_or_clock_loss_pin}, 8'h01);
    check("fallback", {7'h00, tx_clock_select_rx}, 8'h01);
    clock_loss_pin_enable <= 1'b0;
    tx_fallback_enable <= 1'b0;
    repeat (4) @(posedge clk);
    check("pin off", {7'h00, sync_or_clock_loss_pin}, 8'h00);
    check("fallback off", {7'h00, tx_clock_select_rx}, 8'h00);
    tx_run <= 1'b1;
    repeat (40) @(posedge rx_line_clock);
    probe(8'h20, v); check("tx back", v, 8'h00);
  endtask
  // Slip event is sticky, then clears
  task t_slip();
    logic [7:0] v;
    sr(8'h10, v);
    @(posedge rx_line_clock) rx_slip_pulse <= 1'b1;
    @(posedge rx_line_clock) rx_slip_pulse <= 1'b0;
    repeat (10) @(posedge clk);
    sr(8'h10, v); check("slip", v & 8'h10, 8'h10);
    sr(8'h10, v); check("slip gone", v & 8'h10, 8'h00);
  endtask
  // Red, blue and loop codes from line patterns
  task t_line();
    logic [7:0] v;
    for (int k = 0; k < 10; k++) begin
      @(posedge rx_line_clock) period <= lp[k][3:0];
      repeat (ln[k]) @(posedge rx_line_clock);
      if (lm[k] != 8'h00) begin
        probe(lm[k], v);
        check("line alarm", v, le[k]);
      end
    end
  endtask
  // Yellow in each of its three modes
  task t_yellow();
    logic [7:0] v;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      {esf_mode, yellow_fbit12_mode} <= 2'(yk[k]);
      repeat (10) @(posedge clk);
      for (int i = 0; i < yt[k]; i++) begin
        @(posedge rx_line_clock);
        {chan_bit2_valid, fbit12_valid, fdl_pattern_valid} <= 3'h4 >> yk[k];
        {fbit12, fdl_is_00ff, chan_bit2} <= {{2{i < yn[k]}}, i >= yn[k]};
        @(posedge rx_line_clock);
        {chan_bit2_valid, fbit12_valid, fdl_pattern_valid} <= 3'h0;
      end
      probe(8'h04, v); check("yellow", v, ye[k]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard
  initial begin
    #3000000;
    err_total++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {resetn, rx_in_sync, rx_slip_pulse, chan_bit2_valid, chan_bit2} = 5'h00;
    {fbit12_valid, fbit12, fdl_pattern_valid, fdl_is_00ff} = 4'h0;
    {yellow_fbit12_mode, esf_mode, clock_loss_pin_enable} = 3'h0;
    {tx_fallback_enable, reg_write, reg_read} = 3'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    period = 4'h1;
    tx_run = 1'b1;
    err_total = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_tx();
    t_slip();
    t_line();
    t_yellow();
    print_verdict();
  end
endmodule
